//--- rsr_cfg.svh
// Constants for the reset and stop recovery controller
`ifndef RSR_CFG_SVH
`define RSR_CFG_SVH
`define RSR_CLK_NS        50
`define RSR_IPO_START_NS  4000
`define RSR_START_CYC     ((`RSR_IPO_START_NS + `RSR_CLK_NS - 1) / `RSR_CLK_NS)
`define RSR_HOLD_STD      66
`define RSR_HOLD_XTAL     5000
`define RSR_VEC_ADDR      16'h0002
`define RSR_OFF_CAUSE     4'h0
`define RSR_OFF_OSC       4'h4
`define RSR_OFF_WDT       4'h8
`define RSR_OFF_MODE      4'hC
`define RSR_BIT_STOP      7
`define RSR_BIT_WDT       5
`define RSR_BIT_EXT       4
`define RSR_OSC_RST       8'h08
`define RSR_OSC_WDTOSC    3
`define RSR_CLK_IPO       2'h0
`define RSR_WDT_RST       8'h00
`define RSR_WDT_EN        0
`define RSR_WDT_RSTEN     1
`define RSR_PWR_RST       10'h00C
`define RSR_RESP_OKAY     2'h0
`define RSR_RESP_SLVERR   2'h2
`endif

//--- rsr_far_model.sv
// Far side model: reset pin, watchdog and core events
module rsr_far_model (
    input  wire logic       i_clk,
    output logic            o_ext_rst_n,
    output logic            o_wdt_timeout,
    output logic [3:0]      o_evt
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_ext_rst_n = 1'b1;
        o_wdt_timeout = 1'b0;
        o_evt = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Pin held low for n cycles; no bounce modelled
    task automatic hold_pin(input int n);
        @(posedge i_clk) o_ext_rst_n <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_ext_rst_n <= 1'b1;
    endtask
    // One-cycle event: 0 stop, 1 sleep, 2 wake, 3 pin change
    task automatic pulse(input int k);
        @(posedge i_clk) o_evt[k] <= 1'b1;
        @(posedge i_clk) o_evt[k] <= 1'b0;
    endtask
    // Timeout is a level, like the slow counter it stands for
    task automatic set_wdt(input logic v);
        @(posedge i_clk) o_wdt_timeout <= v;
    endtask
endmodule

//--- rsr_pkg.sv
// Types for the reset and stop recovery controller
package rsr_pkg;
    typedef enum logic [6:0] {
        S_PWRUP = 7'h01,
        S_OSCUP = 7'h02,
        S_HOLD  = 7'h04,
        S_EXTW  = 7'h08,
        S_RUN   = 7'h10,
        S_SLEEP = 7'h20,
        S_STOP  = 7'h40
    } rsr_state_t;

    typedef struct packed {
        logic ipo_run;
        logic xtal_run;
        logic xtal_pins_rel;
        logic sysclk_run;
        logic core_run;
        logic periph_run;
        logic gpio_safe;
        logic wdt_osc_run;
        logic wdt_run;
        logic bo_run;
    } rsr_pwr_t;
endpackage

//--- rsr_top.sv
// Reset, stop recovery and power mode controller with AXI4-Lite registers
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`include "rsr_cfg.svh"
module rsr_top
    import rsr_pkg::*;
#(
    parameter int START_CYC  = `RSR_START_CYC,
    parameter int HOLD_STD   = `RSR_HOLD_STD,
    parameter int HOLD_XTAL  = `RSR_HOLD_XTAL,
    parameter int CNT_W      = 13
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_clk_en,
    input  wire logic        i_supply_ok,
    input  wire logic        i_ext_rst_n,
    input  wire logic        i_xtal_opt,
    input  wire logic        i_bo_stop_opt,
    input  wire logic        i_stop_exec,
    input  wire logic        i_sleep_exec,
    input  wire logic        i_wake,
    input  wire logic        i_pin_change,
    input  wire logic        i_wdt_timeout,
    input  wire logic [3:0]  i_axi_awaddr,
    input  wire logic        i_axi_awvalid,
    output logic             o_axi_awready,
    input  wire logic [31:0] i_axi_wdata,
    input  wire logic [3:0]  i_axi_wstrb,
    input  wire logic        i_axi_wvalid,
    output logic             o_axi_wready,
    output logic [1:0]       o_axi_bresp,
    output logic             o_axi_bvalid,
    input  wire logic        i_axi_bready,
    input  wire logic [3:0]  i_axi_araddr,
    input  wire logic        i_axi_arvalid,
    output logic             o_axi_arready,
    output logic [31:0]      o_axi_rdata,
    output logic [1:0]       o_axi_rresp,
    output logic             o_axi_rvalid,
    input  wire logic        i_axi_rready,
    output logic             o_core_rst,
    output logic             o_vec_fetch,
    output logic [15:0]      o_vec_addr,
    output logic [1:0]       o_clk_sel,
    output logic             o_wdt_irq,
    output rsr_pwr_t         o_pwr
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic is_mapped(input logic [3:0] a);
        is_mapped = (a == `RSR_OFF_CAUSE) || (a == `RSR_OFF_OSC) ||
                    (a == `RSR_OFF_WDT) || (a == `RSR_OFF_MODE);
    endfunction

    function automatic logic in_reset(input rsr_state_t s);
        in_reset = (s == S_PWRUP) || (s == S_OSCUP) ||
                   (s == S_HOLD) || (s == S_EXTW);
    endfunction

    rsr_state_t        state_q;
    rsr_state_t        state_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic [7:0]        osc_q;
    logic [7:0]        wdt_q;
    logic [2:0]        cause_q;
    logic [2:0]        cause_d;
    logic              ext_q;
    logic              wdto_q;
    logic              bvalid_q;
    logic              rvalid_q;
    logic [1:0]        bresp_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;
    logic              vec_q;
    logic              core_rst_q;
    rsr_pwr_t          pwr_q;
    rsr_pwr_t          pwr_d;

    ////////////////////////////////////////////////////////////////////////
    // Event decode
    wire por       = !i_supply_ok;
    wire ext_fall  = ext_q && !i_ext_rst_n;
    wire wdt_rise  = i_wdt_timeout && !wdto_q;
    wire in_stop   = (state_q == S_STOP);
    wire wdt_en    = wdt_q[`RSR_WDT_EN];
    wire wdt_rsten = wdt_q[`RSR_WDT_RSTEN];
    wire smr_wdt   = in_stop && wdt_rise && wdt_en;
    wire smr_pin   = in_stop && i_pin_change;
    wire smr_any   = smr_wdt || smr_pin;
    wire wdt_sysr  = !in_stop && wdt_rise && wdt_en && wdt_rsten &&
                     !in_reset(state_q);
    // A fresh pin fall during the count restarts it from zero
    wire restart   = ext_fall || wdt_sysr || smr_any;
    wire hold_end  = (cnt_q == CNT_W'((i_xtal_opt ? HOLD_XTAL
                                                  : HOLD_STD) - 1));
    wire start_end = (cnt_q == CNT_W'(START_CYC - 1));
    wire regs_init = por || restart;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + CNT_W'(1);
        case (state_q)
            S_PWRUP: begin
                cnt_d = '0;
                // Supply-good counts directly, oscillator already settled
                if (i_supply_ok) state_d = S_HOLD;
            end
            S_OSCUP: begin
                if (start_end) begin
                    state_d = S_HOLD;
                    cnt_d   = '0;
                end
            end
            S_HOLD: begin
                if (hold_end) begin
                    cnt_d   = '0;
                    state_d = i_ext_rst_n ? S_RUN : S_EXTW;
                end
            end
            S_EXTW: begin
                cnt_d = '0;
                if (i_ext_rst_n) state_d = S_RUN;
            end
            S_RUN: begin
                cnt_d = '0;
                if (i_stop_exec) state_d = S_STOP;
                else if (i_sleep_exec) state_d = S_SLEEP;
            end
            S_SLEEP: begin
                cnt_d = '0;
                if (i_wake) state_d = S_RUN;
            end
            S_STOP: cnt_d = '0;
            default: begin
                state_d = S_PWRUP;
                cnt_d   = '0;
            end
        endcase
        if (restart) begin
            state_d = S_OSCUP;
            cnt_d   = '0;
        end
        if (por) begin
            state_d = S_PWRUP;
            cnt_d   = '0;
        end
    end

    // Power controls follow the next state so they align with the state
    wire stop_d  = (state_d == S_STOP);
    wire rst_d   = in_reset(state_d);
    always_comb begin
        pwr_d               = '0;
        pwr_d.ipo_run       = !stop_d && (state_d != S_PWRUP);
        pwr_d.xtal_run      = i_xtal_opt && !stop_d;
        pwr_d.xtal_pins_rel = stop_d || !i_xtal_opt;
        pwr_d.sysclk_run    = !stop_d;
        pwr_d.core_run      = (state_d == S_RUN);
        pwr_d.periph_run    = !stop_d && !rst_d;
        pwr_d.gpio_safe     = rst_d;
        pwr_d.wdt_osc_run   = osc_q[`RSR_OSC_WDTOSC] || rst_d;
        pwr_d.wdt_run       = wdt_en;
        pwr_d.bo_run        = !stop_d || i_bo_stop_opt;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            state_q    <= S_PWRUP;
            cnt_q      <= '0;
            ext_q      <= 1'b1;
            wdto_q     <= 1'b0;
            pwr_q      <= `RSR_PWR_RST;
            core_rst_q <= 1'b1;
            vec_q      <= 1'b0;
        end else if (i_clk_en) begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            ext_q      <= i_ext_rst_n;
            wdto_q     <= i_wdt_timeout;
            pwr_q      <= pwr_d;
            core_rst_q <= rst_d;
            // Vector fetch strobe on release from any reset
            vec_q      <= (state_d == S_RUN) && in_reset(state_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset cause flags: set beats clear, power-on beats both
    wire rd_cause = o_axi_arready && i_axi_arvalid &&
                    (i_axi_araddr == `RSR_OFF_CAUSE);
    wire [2:0] flag_set = {smr_any, wdt_rise, ext_fall};
    wire [2:0] flag_clr = {(wdt_rise && !in_stop) || rd_cause,
                           smr_pin || rd_cause,
                           smr_pin || rd_cause};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_flag
            assign cause_d[gi] = por ? 1'b0 :
                flag_set[gi] | (cause_q[gi] & ~flag_clr[gi]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave; one beat in flight per direction
    wire wr_take = i_axi_awvalid && i_axi_wvalid && !bvalid_q && i_clk_en;
    wire wr_osc  = wr_take && (i_axi_awaddr == `RSR_OFF_OSC) &&
                   i_axi_wstrb[0] && !in_reset(state_q);
    wire wr_wdt  = wr_take && (i_axi_awaddr == `RSR_OFF_WDT) &&
                   i_axi_wstrb[0] && !in_reset(state_q);
    wire [7:0] cause_rd = {cause_q[2], 1'b0, cause_q[1], cause_q[0], 4'h0};
    wire [31:0] rd_mux =
        (i_axi_araddr == `RSR_OFF_CAUSE) ? {24'h0, cause_rd} :
        (i_axi_araddr == `RSR_OFF_OSC)   ? {24'h0, osc_q} :
        (i_axi_araddr == `RSR_OFF_WDT)   ? {24'h0, wdt_q} :
        (i_axi_araddr == `RSR_OFF_MODE)  ? {25'h0, state_q} : 32'h0;

    assign o_axi_awready = wr_take;
    assign o_axi_wready  = wr_take;
    assign o_axi_arready = !rvalid_q && i_clk_en;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cause_q  <= '0;
            osc_q    <= `RSR_OSC_RST;
            wdt_q    <= `RSR_WDT_RST;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            bresp_q  <= `RSR_RESP_OKAY;
            rresp_q  <= `RSR_RESP_OKAY;
            rdata_q  <= 32'h0;
        end else if (i_clk_en) begin
            cause_q <= cause_d;
            if (regs_init) begin
                osc_q <= `RSR_OSC_RST;
                wdt_q <= `RSR_WDT_RST;
            end else begin
                if (wr_osc) osc_q <= i_axi_wdata[7:0];
                if (wr_wdt) wdt_q <= i_axi_wdata[7:0];
            end
            if (wr_take) begin
                bvalid_q <= 1'b1;
                bresp_q  <= is_mapped(i_axi_awaddr) ? `RSR_RESP_OKAY
                                                    : `RSR_RESP_SLVERR;
            end else if (i_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (o_axi_arready && i_axi_arvalid) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_mux;
                rresp_q  <= is_mapped(i_axi_araddr) ? `RSR_RESP_OKAY
                                                    : `RSR_RESP_SLVERR;
            end else if (i_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign o_axi_bvalid = bvalid_q;
    assign o_axi_bresp  = bresp_q;
    assign o_axi_rvalid = rvalid_q;
    assign o_axi_rresp  = rresp_q;
    assign o_axi_rdata  = rdata_q;
    assign o_core_rst   = core_rst_q;
    assign o_vec_fetch  = vec_q;
    assign o_vec_addr   = `RSR_VEC_ADDR;
    assign o_clk_sel    = osc_q[1:0];
    // Level follows the slow-domain timeout for as long as it lasts
    assign o_wdt_irq    = i_wdt_timeout && wdt_en && !wdt_rsten;
    assign o_pwr        = pwr_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence hold_done_s;
        state_q == S_HOLD ##1 state_q == S_RUN;
    endsequence
    sequence pin_smr_s;
        in_stop && i_pin_change && i_supply_ok;
    endsequence

    start_len_a: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        (state_q == S_OSCUP && state_d == S_HOLD && !restart && !por)
        |-> cnt_q == CNT_W'(START_CYC - 1))
        else $error("startup interval wrong length");
    hold_std_a: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        (state_q == S_HOLD && state_d == S_RUN && !i_xtal_opt)
        |-> cnt_q == CNT_W'(HOLD_STD - 1))
        else $error("reset hold not 66 cycles");
    hold_xtal_a: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        (state_q == S_HOLD && i_xtal_opt &&
         cnt_q < CNT_W'(HOLD_XTAL - 1)) |=> state_q != S_RUN)
        else $error("crystal hold released early");
    ext_wait_a: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        (state_q == S_EXTW && !i_ext_rst_n && i_supply_ok)
        |=> state_q == S_EXTW && o_core_rst)
        else $error("left reset while pin asserted");
    gpio_safe_a: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        o_core_rst |-> o_pwr.gpio_safe && !o_pwr.periph_run)
        else $error("pins not safe during reset");
    vec_fetch_a: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        hold_done_s |-> o_vec_fetch && !o_core_rst ##1 !o_vec_fetch)
        else $error("vector fetch strobe missing");
    stop_flag_a: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        pin_smr_s |=> cause_q[2] && !cause_q[1] && state_q == S_OSCUP)
        else $error("pin recovery flags wrong");
    read_clr_a: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        (rd_cause && flag_set == 3'h0) |=> cause_q == 3'h0)
        else $error("cause read did not clear");
    stop_pwr_a: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        state_q == S_STOP |-> !o_pwr.ipo_run && !o_pwr.sysclk_run &&
        !o_pwr.core_run && o_pwr.xtal_pins_rel)
        else $error("stop mode left clocks running");
    clk_ipo_a: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        $rose(o_core_rst) |=> o_clk_sel == `RSR_CLK_IPO)
        else $error("clock source not internal after reset");

endmodule

//--- rsr_top_tb_top.sv
// Testbench for the reset and stop recovery controller
module rsr_top_tb_top import rsr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int START = 4;
    localparam int HOLD  = 66;
    localparam int XHOLD = 20;
    typedef struct packed {
        logic        wr;
        logic [3:0]  a;
        logic [31:0] d;
        logic [1:0]  r;
    } rsr_row_t;
    rsr_row_t    rows [10] = '{
        '{1'b0, 4'h0, 32'h00, 2'h0}, '{1'b0, 4'h4, 32'h08, 2'h0},
        '{1'b0, 4'h8, 32'h00, 2'h0}, '{1'b0, 4'hC, 32'h10, 2'h0},
        '{1'b1, 4'h4, 32'h0B, 2'h0}, '{1'b0, 4'h4, 32'h0B, 2'h0},
        '{1'b1, 4'h2, 32'h55, 2'h2}, '{1'b0, 4'h2, 32'h00, 2'h2},
        '{1'b1, 4'h8, 32'h01, 2'h0}, '{1'b0, 4'h8, 32'h01, 2'h0}};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        supply_ok = 1'b1;
    logic        xtal = 1'b0;
    logic        clk_en = 1'b1;
    logic        bo_opt = 1'b1;
    logic [3:0]  wstrb = 4'hF;
    logic [3:0]  awaddr = 4'h0;
    logic [3:0]  araddr = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic        awready, wready, bvalid, arready, rvalid, core_rst;
    logic        vec_fetch, wdt_irq, ext_n, wdt_to;
    logic [1:0]  bresp, rresp, clk_sel;
    logic [31:0] rdata;
    logic [15:0] vec_addr;
    logic [3:0]  evt;
    rsr_pwr_t    pwr;
    int          err_count = 0;
    int          check_count = 0;
    always #25 clk = ~clk;
    rsr_top #(.START_CYC(START), .HOLD_STD(HOLD), .HOLD_XTAL(XHOLD)) dut (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(clk_en),
        .i_supply_ok(supply_ok), .i_ext_rst_n(ext_n), .i_xtal_opt(xtal),
        .i_bo_stop_opt(bo_opt), .i_stop_exec(evt[0]), .i_sleep_exec(evt[1]),
        .i_wake(evt[2]), .i_pin_change(evt[3]), .i_wdt_timeout(wdt_to),
        .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
        .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb),
        .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp),
        .o_axi_bvalid(bvalid), .i_axi_bready(bready), .i_axi_araddr(araddr),
        .i_axi_arvalid(arvalid), .o_axi_arready(arready),
        .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
        .i_axi_rready(rready), .o_core_rst(core_rst),
        .o_vec_fetch(vec_fetch), .o_vec_addr(vec_addr), .o_clk_sel(clk_sel),
        .o_wdt_irq(wdt_irq), .o_pwr(pwr));
    rsr_far_model far (.i_clk(clk), .o_ext_rst_n(ext_n),
        .o_wdt_timeout(wdt_to), .o_evt(evt));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                          output logic [1:0] resp);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(negedge clk); while ((awready && wready) !== 1'b1);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do @(negedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(negedge clk); while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask
    // Reads one register and compares data only
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check("register read", d, exp);
    endtask
    // Counts cycles with the core held; ends where the release shows
    task automatic hold_len(output int n);
        n = 0;
        do @(negedge clk); while (core_rst !== 1'b1 && ++n < 100);
        check("gpio_safe", pwr.gpio_safe, 1'b1);
        n = 0;
        while (core_rst === 1'b1 && n < 10000) begin
            n++;
            @(negedge clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int          n;
        logic [31:0] d;
        logic [1:0]  r;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check("core_rst", core_rst, 1'b1);
        check("pwr", {pwr.gpio_safe, pwr.periph_run}, 2'b10);
        @(posedge clk) rst <= 1'b0;
        do @(negedge clk); while (core_rst !== 1'b0 && ++n < 300);
        check("hold reset", n, HOLD + 1);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_wr(rows[i].a, rows[i].d, r);
            end else begin
                axi_rd(rows[i].a, d, r);
                check("rdata", d, rows[i].d);
            end
            check("resp", r, rows[i].r);
        end
        fork far.hold_pin(2); hold_len(n); join
        check("hold std", n, START + HOLD);
        check("vec_fetch", vec_fetch, 1'b1);
        check("vec_addr", vec_addr, 16'h0002);
        check("clk_sel", clk_sel, 2'h0);
        rd_chk(4'h4, 32'h08);
        rd_chk(4'h0, 32'h10);
        rd_chk(4'h0, 32'h00);
        // Pin outlasts the count: release must wait for it
        far.hold_pin(150);
        @(negedge clk);
        check("core_rst held", core_rst, 1'b1);
        repeat (3) @(negedge clk);
        check("core_rst freed", core_rst, 1'b0);
        @(posedge clk) xtal <= 1'b1;
        fork far.hold_pin(2); hold_len(n); join
        check("hold xtal", n, START + XHOLD);
        @(posedge clk) xtal <= 1'b0;
        axi_wr(4'h8, 32'h01, r);
        far.set_wdt(1'b1);
        repeat (5) @(negedge clk);
        check("wdt_irq on", wdt_irq, 1'b1);
        far.set_wdt(1'b0);
        @(negedge clk);
        check("wdt_irq off", wdt_irq, 1'b0);
        rd_chk(4'h0, 32'h30);
        rd_chk(4'h0, 32'h00);
        far.set_wdt(1'b1);
        far.set_wdt(1'b0);
        far.pulse(0);
        repeat (3) @(negedge clk);
        check("stop core", {pwr.core_run, pwr.periph_run}, 2'b00);
        check("stop clocks", {pwr.ipo_run, pwr.sysclk_run}, 2'b00);
        check("stop pins", pwr.xtal_pins_rel, 1'b1);
        check("stop wdt", {pwr.wdt_osc_run, pwr.wdt_run}, 2'b11);
        check("stop brownout", pwr.bo_run, 1'b1);
        @(posedge clk) bo_opt <= 1'b0;
        repeat (2) @(negedge clk);
        check("stop brownout off", pwr.bo_run, 1'b0);
        @(posedge clk) bo_opt <= 1'b1;
        far.pulse(3);
        n = 0;
        do @(negedge clk); while (core_rst !== 1'b0 && ++n < 300);
        check("hold smr", n, START + HOLD);
        rd_chk(4'h0, 32'h80);
        rd_chk(4'h8, 32'h00);
        far.pulse(1);
        repeat (3) @(negedge clk);
        check("sleep", {pwr.core_run, pwr.periph_run}, 2'b01);
        far.pulse(2);
        repeat (3) @(negedge clk);
        check("wake", pwr.core_run, 1'b1);
        far.hold_pin(150);
        @(posedge clk) supply_ok <= 1'b0;
        repeat (3) @(negedge clk);
        check("supply low", core_rst, 1'b1);
        @(posedge clk) supply_ok <= 1'b1;
        n = 0;
        do @(negedge clk); while (core_rst !== 1'b0 && ++n < 300);
        check("hold por", n, HOLD + 1);
        rd_chk(4'h0, 32'h00);
        // Lane zero disabled: the write must leave the register alone
        @(posedge clk) wstrb <= 4'h0;
        axi_wr(4'h4, 32'h03, r);
        wstrb <= 4'hF;
        check("resp strb", r, 2'h0);
        rd_chk(4'h4, 32'h08);
        // Enable low freezes everything, so the stop request is lost
        @(posedge clk) clk_en <= 1'b0;
        far.pulse(0);
        @(negedge clk);
        check("frozen ready", arready, 1'b0);
        @(posedge clk) clk_en <= 1'b1;
        repeat (2) @(negedge clk);
        check("frozen stop", pwr.core_run, 1'b1);
        // Timeout with reset enabled restarts the sequence, no interrupt
        axi_wr(4'h8, 32'h03, r);
        far.set_wdt(1'b1);
        @(negedge clk);
        check("wdt_irq rst", wdt_irq, 1'b0);
        far.set_wdt(1'b0);
        n = 0;
        do @(negedge clk); while (core_rst !== 1'b0 && ++n < 300);
        check("hold wdt", n, START + HOLD);
        rd_chk(4'h0, 32'h20);
        // Mid-run system reset brings registers back to reset values
        axi_wr(4'h4, 32'h0B, r);
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        @(negedge clk);
        check("rst core", {core_rst, pwr.gpio_safe}, 2'b11);
        n = 0;
        do @(negedge clk); while (core_rst !== 1'b0 && ++n < 300);
        check("hold rst", n, HOLD);
        rd_chk(4'h4, 32'h08);
        finish_test();
    end
    // Whole run is under a thousand cycles; this is 20000 cycles, far beyond it
    initial begin
        #(50 * 20000);
        err_count++;
        finish_test();
    end
endmodule
